// *** hw/motor_status_map.svh ***
`ifndef MOTOR_STATUS_MAP_SVH
`define MOTOR_STATUS_MAP_SVH
`define MST_CLK_NS 50
`define MST_TICK_US 1000
`define MST_STOP_MS 10
`define MST_RISE_MS 10
`define MST_PU_MIN 16'h0001
`define MST_PU_MAX 16'h0190
`define MST_OFF_CTRL 6'h00
`define MST_OFF_THR0 6'h01
`define MST_OFF_FACT 6'h08
`define MST_OFF_STAT 6'h09
`define MST_OFF_EVON 6'h0A
`define MST_OFF_EVOFF 6'h0B
`define MST_OFF_PEND 6'h0C
`define MST_OFF_MASK 6'h0D
`define MST_OFF_CNT0 6'h0E
`define MST_OFF_LAST 6'h15
`define MST_RST_NOLOAD 16'h0002
`define MST_RST_STARTDET 16'h000F
`define MST_RST_MINLOCK 16'h0023
`define MST_RST_NOMSTART 16'h003C
`define MST_RST_MAXLOCK 16'h004B
`define MST_RST_MAXOVL 16'h0014
`define MST_RST_NOMINAL 16'h000A
`define MST_RST_FACT 32'h0064_0064
`define MST_CTRL_FEN 0
`define MST_CTRL_SEL 1
`define MST_CTRL_MODE 5
`define MST_ST_STOPPED 0
`define MST_ST_STARTING 1
`define MST_ST_RUNNING 2
`define MST_ST_NORMAL 3
`define MST_ST_OVERLOAD 4
`define MST_ST_STALLED 5
`define MST_ST_MISSING 6
`define MST_ST_OVERCUR 7
`define MST_ST_STALLTC 8
`define MST_ST_UCLOCK 9
`endif

// *** hw/motor_status_monitor.sv ***
// Chosen here: the placing of the registers and the APB register port.
`include "motor_status_map.svh"
module motor_status_monitor #(
	parameter int TICK_CYCLES = `MST_TICK_US * 1000 / `MST_CLK_NS,
	parameter int CW = 16
)(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Phase currents, 0.1 x In per unit
	input wire logic measValid,
	input wire logic [CW-1:0] phaseA,
	input wire logic [CW-1:0] phaseB,
	input wire logic [CW-1:0] phaseC,
	// Status and interrupt
	output logic [9:0] statusOut,
	output logic irq
);
	localparam logic [7:0] STOP_TICKS =
		8'(`MST_STOP_MS * 1000 / `MST_TICK_US);
	localparam logic [7:0] RISE_TICKS =
		8'(`MST_RISE_MS * 1000 / `MST_TICK_US);
	localparam logic [CW-1:0] THR_RST [0:6] = '{
		`MST_RST_NOLOAD, `MST_RST_STARTDET, `MST_RST_MINLOCK,
		`MST_RST_NOMSTART, `MST_RST_MAXLOCK, `MST_RST_MAXOVL,
		`MST_RST_NOMINAL};

	logic tick;
	logic [CW-1:0] thr_r [0:6];
	logic [31:0] fact_r;
	logic [6:0] ctrl_r;
	logic [9:0] evOn_r, evOff_r;
	logic [19:0] mask_r;
	logic [31:0] cnt_r [0:6];
	logic [31:0] upMs_r;
	logic [CW-1:0] maxI_r, minI_r, nomEff_r;
	logic [7:0] lowCnt_r, riseCnt_r;
	logic [9:0] status_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;
	motor_status_pkg::state_type state_r, stateNxt;

	mst_evt_if ev ();

	mst_tick_div #(.N(TICK_CYCLES)) u_div (
		.clk(clk),
		.reset(reset),
		.tick(tick)
	);

	mst_event_unit u_evt (
		.clk(clk),
		.reset(reset),
		.ev(ev.unit)
	);

	// Register decode
	wire [5:0] widx = paddr[7:2];
	wire aligned = paddr[1:0] == 2'b00;
	wire mapped = aligned && widx <= `MST_OFF_LAST;
	wire setup = psel && !penable;
	wire wrEn = psel && penable && pwrite && pready_r && mapped;
	wire isThr = widx >= `MST_OFF_THR0 && widx < `MST_OFF_FACT;
	wire [2:0] thrIdx = 3'(widx - `MST_OFF_THR0);
	// Last word is reserved and must read 0, not a counter
	wire isCnt = widx >= `MST_OFF_CNT0 && widx < `MST_OFF_LAST;
	wire [2:0] cntIdx = 3'(widx - `MST_OFF_CNT0);
	wire clrCnt = wrEn && isCnt;

	function automatic logic [CW-1:0] clampPu(input logic [31:0] v);
		if (v < 32'(`MST_PU_MIN))
			return `MST_PU_MIN;
		else if (v > 32'(`MST_PU_MAX))
			return `MST_PU_MAX;
		else
			return CW'(v);
	endfunction

	function automatic logic [31:0] readSel(input logic [5:0] i);
		case (i)
			`MST_OFF_CTRL: return {25'h0, ctrl_r};
			`MST_OFF_FACT: return fact_r;
			`MST_OFF_STAT: return {22'h0, status_r};
			`MST_OFF_EVON: return {22'h0, evOn_r};
			`MST_OFF_EVOFF: return {22'h0, evOff_r};
			`MST_OFF_PEND: return {12'h0, ev.pend};
			`MST_OFF_MASK: return {12'h0, mask_r};
			default: begin
				if (isThr)
					return 32'(thr_r[thrIdx]);
				else if (isCnt)
					return cnt_r[cntIdx];
				else
					return 32'h0;
			end
		endcase
	endfunction

	wire [31:0] readVal = readSel(widx);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && !mapped;
			if (setup)
				prdata_r <= mapped && !pwrite ? readVal : 32'h0;
		end
	end

	// mode and force fields, reset to line start, no force
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_r <= 7'h00;
			fact_r <= `MST_RST_FACT;
			evOn_r <= 10'h000;
			evOff_r <= 10'h000;
			mask_r <= 20'h00000;
		end else if (wrEn) begin
			case (widx)
				`MST_OFF_CTRL: ctrl_r <= pwdata[6:0];
				`MST_OFF_FACT: fact_r <= pwdata;
				`MST_OFF_EVON: evOn_r <= pwdata[9:0];
				`MST_OFF_EVOFF: evOff_r <= pwdata[9:0];
				`MST_OFF_MASK: mask_r <= pwdata[19:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 7; i++)
				thr_r[i] <= THR_RST[i];
		end else if (wrEn && isThr) begin
			thr_r[thrIdx] <= clampPu(pwdata);
		end
	end

	wire [CW-1:0] noLoad = thr_r[0];
	wire [CW-1:0] startDet = thr_r[1];
	wire [CW-1:0] maxLock = thr_r[4];
	wire [CW-1:0] maxOvl = thr_r[5];
	wire forceEn = ctrl_r[`MST_CTRL_FEN];
	wire [3:0] forceSel = ctrl_r[`MST_CTRL_SEL +: 4];
	wire softMode = ctrl_r[`MST_CTRL_MODE +: 2] ==
		motor_status_pkg::soft_start;

	wire [CW-1:0] mAB = phaseA > phaseB ? phaseA : phaseB;
	wire [CW-1:0] nAB = phaseA < phaseB ? phaseA : phaseB;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			maxI_r <= '0;
			minI_r <= '0;
			nomEff_r <= `MST_RST_NOMINAL;
		end else begin
			if (measValid) begin
				maxI_r <= mAB > phaseC ? mAB : phaseC;
				minI_r <= nAB < phaseC ? nAB : phaseC;
			end
			// nominal derated by service and ambient factors
			nomEff_r <= CW'((48'(thr_r[6]) * 48'(fact_r[15:0]) *
				48'(fact_r[31:16])) / 48'h2710);
		end
	end

	wire below = maxI_r < noLoad;
	wire aboveStart = maxI_r > startDet;
	wire aboveNom = maxI_r > nomEff_r;
	wire aboveOvl = maxI_r > maxOvl;
	wire aboveLock = maxI_r > maxLock;
	wire phaseLow = minI_r < noLoad;
	wire lowQual = lowCnt_r > STOP_TICKS;
	wire startSeen = aboveStart && !below &&
		(softMode || riseCnt_r <= RISE_TICKS);

	// low-current and rise timers in 1 ms ticks
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lowCnt_r <= 8'h00;
			riseCnt_r <= 8'h00;
		end else begin
			if (!below)
				lowCnt_r <= 8'h00;
			else if (tick && !lowQual)
				lowCnt_r <= lowCnt_r + 8'h01;
			if (below)
				riseCnt_r <= 8'h00;
			else if (tick && riseCnt_r <= RISE_TICKS)
				riseCnt_r <= riseCnt_r + 8'h01;
		end
	end

	always_comb begin
		stateNxt = state_r;
		case (state_r)
			motor_status_pkg::MOTOR_STOPPED: begin
				if (startSeen)
					stateNxt = motor_status_pkg::MOTOR_STARTING;
			end
			motor_status_pkg::MOTOR_STARTING: begin
				if (lowQual)
					stateNxt = motor_status_pkg::MOTOR_STOPPED;
				else if (!below && maxI_r < maxOvl)
					stateNxt = motor_status_pkg::MOTOR_RUNNING;
			end
			motor_status_pkg::MOTOR_RUNNING: begin
				if (lowQual)
					stateNxt = motor_status_pkg::MOTOR_STOPPED;
			end
			default: stateNxt = motor_status_pkg::MOTOR_STOPPED;
		endcase
	end

	wire inStop = state_r == motor_status_pkg::MOTOR_STOPPED;
	wire inStart = state_r == motor_status_pkg::MOTOR_STARTING;
	wire inRun = state_r == motor_status_pkg::MOTOR_RUNNING;
	wire goStart = inStop && stateNxt == motor_status_pkg::MOTOR_STARTING;
	wire goRun = inStart && stateNxt == motor_status_pkg::MOTOR_RUNNING;
	wire goStop = !inStop && stateNxt == motor_status_pkg::MOTOR_STOPPED;

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			state_r <= motor_status_pkg::MOTOR_STOPPED;
		else
			state_r <= stateNxt;
	end

	// counters: starts, good, stops, run, start, stop ms, last stop
	wire [6:0] cntInc = {1'b0, tick && inStop, tick && inStart,
		tick && inRun, goStop, goRun, goStart};
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 7; i++)
				cnt_r[i] <= 32'h0;
			upMs_r <= 32'h0;
		end else begin
			upMs_r <= upMs_r + 32'(tick);
			for (int i = 0; i < 6; i++)
				cnt_r[i] <= (clrCnt && cntIdx == 3'(i)) ? 32'h0 :
					cnt_r[i] + 32'(cntInc[i]);
			if (goStop)
				cnt_r[6] <= upMs_r;
		end
	end

	function automatic logic [6:0] forceMap(input logic [3:0] s);
		case (s)
			motor_status_pkg::force_halted: return 7'h01;
			motor_status_pkg::force_accelerating: return 7'h02;
			motor_status_pkg::force_turning: return 7'h04;
			motor_status_pkg::force_locked: return 7'h24;
			motor_status_pkg::force_unbalanced_load: return 7'h44;
			motor_status_pkg::force_nominal_load: return 7'h0C;
			motor_status_pkg::force_overload: return 7'h14;
			motor_status_pkg::force_severe_overload: return 7'h20;
			default: return 7'h00;
		endcase
	endfunction

	wire forceOn = forceEn && forceSel != 4'h0;
	wire [6:0] rawSt = {
		// one phase lost while starting or running
		(inStart || inRun) && phaseLow && !below,
		inRun && aboveOvl,
		inRun && aboveNom && !aboveOvl,
		inRun && !below && !aboveNom,
		inRun, inStart,
		inStop && lowQual};
	// overcurrent, stall time constant, undercurrent lock
	wire [9:0] statusNxt = {below, aboveOvl, aboveLock,
		forceOn ? forceMap(forceSel) : rawSt};

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			status_r <= 10'h000;
		else
			status_r <= statusNxt;
	end

	// edge events gated by software choice
	assign ev.status = status_r;
	assign ev.enOn = evOn_r;
	assign ev.enOff = evOff_r;
	assign ev.mask = mask_r;
	assign ev.clrWr = wrEn && widx == `MST_OFF_PEND;
	assign ev.clrData = pwdata[19:0];

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign statusOut = status_r;
	assign irq = ev.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_stop_delay;
		$rose(status_r[`MST_ST_STOPPED]) && !$past(forceOn)
			|-> $past(lowCnt_r) > STOP_TICKS;
	endproperty
	a_stop_delay: assert property (p_stop_delay)
		else $error("stopped asserted too early");

	property p_start_thr;
		goStart |-> aboveStart && !below;
	endproperty
	a_start_thr: assert property (p_start_thr)
		else $error("start without start-detect current");

	property p_rise_window;
		goStart && !softMode |-> riseCnt_r <= RISE_TICKS;
	endproperty
	a_rise_window: assert property (p_rise_window)
		else $error("slow rise taken as start");

	property p_run_entry;
		goRun |=> inRun && $past(maxI_r) < $past(maxOvl);
	endproperty
	a_run_entry: assert property (p_run_entry)
		else $error("running entered above max overload");

	property p_normal;
		inRun && !below && !aboveNom && !forceOn
			|=> status_r[`MST_ST_NORMAL] && !status_r[`MST_ST_OVERLOAD];
	endproperty
	a_normal: assert property (p_normal)
		else $error("normal load not flagged");

	property p_overload;
		inRun && aboveNom && !aboveOvl && !forceOn
			|=> status_r[`MST_ST_OVERLOAD] && !status_r[`MST_ST_STALLED];
	endproperty
	a_overload: assert property (p_overload)
		else $error("overloading not flagged");

	property p_stalled;
		inRun && aboveOvl && !forceOn ##1 inRun
			|-> status_r[`MST_ST_STALLED];
	endproperty
	a_stalled: assert property (p_stalled)
		else $error("stall not flagged");

	property p_overcur;
		aboveLock |=> status_r[`MST_ST_OVERCUR] && status_r[`MST_ST_STALLTC];
	endproperty
	a_overcur: assert property (p_overcur)
		else $error("overcurrent fault missed");

	property p_stalltc;
		status_r[`MST_ST_STALLTC] |-> $past(maxI_r) > $past(maxOvl);
	endproperty
	a_stalltc: assert property (p_stalltc)
		else $error("short time constant without cause");
endmodule

// *** hw/motor_status_pkg.sv ***
package motor_status_pkg;
	typedef enum logic [3:0] {
		force_none, force_halted, force_accelerating, force_turning,
		force_locked, force_unbalanced_load, force_nominal_load,
		force_overload, force_severe_overload
	} force_type;
	typedef enum logic [1:0] {
		direct_line_start, star_delta_start, soft_start
	} start_mode_type;
	typedef enum logic [1:0] {
		MOTOR_STOPPED, MOTOR_STARTING, MOTOR_RUNNING
	} state_type;
endpackage

// *** hw/mst_event_unit.sv ***
module mst_event_unit (
	input wire logic clk,
	input wire logic reset,
	mst_evt_if.unit ev
);
	logic [9:0] prev_r;
	logic [19:0] pend_r;
	logic irq_r;
	wire [9:0] rise = ev.status & ~prev_r & ev.enOn;
	wire [9:0] fall = ~ev.status & prev_r & ev.enOff;
	wire [19:0] hit = {fall, rise};
	wire [19:0] clr = ev.clrWr ? ev.clrData : 20'h0;
	// A new edge wins over a write-one-to-clear in the same cycle
	wire [19:0] pendNxt = (pend_r & ~clr) | hit;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_r <= 10'h0;
			pend_r <= 20'h0;
			irq_r <= 1'b0;
		end else begin
			prev_r <= ev.status;
			pend_r <= pendNxt;
			irq_r <= |(pendNxt & ev.mask);
		end
	end
	assign ev.pend = pend_r;
	assign ev.irq = irq_r;
endmodule

// *** hw/mst_evt_if.sv ***
interface mst_evt_if;
	logic [9:0] status;
	logic [9:0] enOn;
	logic [9:0] enOff;
	logic [19:0] mask;
	logic clrWr;
	logic [19:0] clrData;
	logic [19:0] pend;
	logic irq;
	modport main (output status, enOn, enOff, mask, clrWr, clrData,
		input pend, irq);
	modport unit (input status, enOn, enOff, mask, clrWr, clrData,
		output pend, irq);
endinterface

// *** hw/mst_tick_div.sv ***
module mst_tick_div #(
	parameter int N = 20000
)(
	input wire logic clk,
	input wire logic reset,
	output logic tick
);
	logic [31:0] cnt_r;
	wire wrap = cnt_r == 32'(N - 1);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= 32'h0;
			tick <= 1'b0;
		end else begin
			cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
			tick <= wrap;
		end
	end
endmodule

// *** verification/meas_source.sv ***
module meas_source (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Requested current and phase A loss
	input wire logic [15:0] level,
	input wire logic lostA,
	// Measurement path
	output logic measValid,
	output logic [15:0] phaseA,
	output logic [15:0] phaseB,
	output logic [15:0] phaseC
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] slot;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			slot <= 4'h0;
			measValid <= 1'b0;
			phaseA <= 16'h0000;
			phaseB <= 16'h0000;
			phaseC <= 16'h0000;
		end else begin
			slot <= (slot == 4'h9) ? 4'h0 : slot + 4'h1;
			measValid <= (slot == 4'h9);
			if (slot == 4'h9) begin
				phaseA <= lostA ? 16'h0000 : level;
				phaseB <= level;
				phaseC <= level;
			end else begin
				// Junk between samples, so a stale value never passes
				phaseA <= ~phaseA;
				phaseB <= ~phaseB;
				phaseC <= ~phaseC;
			end
		end
	end
endmodule

// *** verification/motor_status_monitor_tb.sv ***
module motor_status_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, psel, penable, pwrite, pready, pslverr;
	logic measValid, irq, lostA, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] phaseA, phaseB, phaseC, level;
	logic [9:0] statusOut;
	int errorCnt, comparisons, cycles;
	logic [15:0] dflt [7] = '{16'h0002, 16'h000F, 16'h0023, 16'h003C,
		16'h004B, 16'h0014, 16'h000A};
	logic [6:0] pat [9] = '{7'h01, 7'h01, 7'h02, 7'h04, 7'h24, 7'h44,
		7'h0C, 7'h14, 7'h20};

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	motor_status_monitor #(.TICK_CYCLES(20), .CW(16)) motor_status_monitor_i (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .measValid(measValid),
		.phaseA(phaseA), .phaseB(phaseB), .phaseC(phaseC),
		.statusOut(statusOut), .irq(irq));

	meas_source meas_source_i (.clk(clk), .reset(reset), .level(level),
		.lostA(lostA), .measValid(measValid), .phaseA(phaseA),
		.phaseB(phaseB), .phaseC(phaseC));

	task automatic test_done();
		if (errorCnt == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Ceiling well above the roughly 2100 cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errorCnt++;
			$display("ERROR %0t: run timed out", $time);
			test_done();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errorCnt++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] data, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the slave
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		data = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic e;
		apb(1'b0, a, 32'h0000_0000, rd, e);
		check(rd, exp);
	endtask

	task automatic waitBit(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (statusOut[b] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, statusOut[b]}, {31'h0, v});
	endtask

	initial begin
		int n;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		level = 16'h0000;
		lostA = 1'b0;
		errorCnt = 0;
		comparisons = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rdc(8'h04 + 8'(4 * i), {16'h0, dflt[i]});
		end
		rdc(8'h20, 32'h0064_0064);
		rdc(8'h00, 32'h0000_0000);
		apb(1'b0, 8'h80, 32'h0, rd, err);
		check({31'h0, err}, 32'h1);
		wr(8'h04, 32'h0);
		rdc(8'h04, 32'h1);
		wr(8'h04, 32'h1F4);
		rdc(8'h04, 32'h190);
		wr(8'h04, 32'h2);
		wr(8'h28, 32'h3FF);
		wr(8'h34, 32'hF_FFFF);
		repeat (100) @(posedge clk);
		check({31'h0, statusOut[0]}, 32'h0);
		waitBit(0, 1'b1, 400);
		check({31'h0, statusOut[9]}, 32'h1);
		wr(8'h30, 32'hF_FFFF);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		level <= 16'h001E;
		waitBit(1, 1'b1, 100);
		apb(1'b0, 8'h30, 32'h0, rd, err);
		check(rd, 32'h0000_0102);
		check({31'h0, rd[1]}, 32'h1);
		check({22'h0, rd[19:10]}, 32'h0);
		check({31'h0, irq}, 32'h1);
		check({31'h0, statusOut[1]}, 32'h1);
		wr(8'h34, 32'h0);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr(8'h34, 32'hF_FFFF);
		level <= 16'h000F;
		waitBit(2, 1'b1, 100);
		waitBit(4, 1'b1, 100);
		level <= 16'h0008;
		waitBit(3, 1'b1, 100);
		check({31'h0, statusOut[4]}, 32'h0);
		level <= 16'h0019;
		waitBit(5, 1'b1, 100);
		waitBit(8, 1'b1, 100);
		level <= 16'h0050;
		waitBit(7, 1'b1, 100);
		level <= 16'h0008;
		lostA <= 1'b1;
		waitBit(6, 1'b1, 100);
		lostA <= 1'b0;
		level <= 16'h0000;
		waitBit(0, 1'b1, 400);
		check({31'h0, statusOut[6]}, 32'h0);
		rdc(8'h38, 32'h1);
		rdc(8'h3C, 32'h1);
		apb(1'b0, 8'h44, 32'h0, rd, err);
		check({31'h0, rd != 32'h0}, 32'h1);
		wr(8'h38, 32'h0);
		rdc(8'h38, 32'h0);
		level <= 16'h0003;
		repeat (300) @(posedge clk);
		level <= 16'h001E;
		repeat (100) @(posedge clk);
		check({31'h0, statusOut[1]}, 32'h0);
		level <= 16'h0000;
		waitBit(0, 1'b1, 400);
		wr(8'h00, 32'h20);
		rdc(8'h00, 32'h20);
		level <= 16'h001E;
		waitBit(1, 1'b1, 100);
		level <= 16'h0000;
		waitBit(0, 1'b1, 400);
		wr(8'h00, 32'h40);
		rdc(8'h00, 32'h40);
		// Soft start takes a slow rise as a start
		level <= 16'h0003;
		repeat (300) @(posedge clk);
		level <= 16'h001E;
		waitBit(1, 1'b1, 100);
		level <= 16'h0000;
		waitBit(0, 1'b1, 400);
		for (int s = 0; s < 9; s++) begin
			wr(8'h00, 32'(s * 2 + 1));
			n = 0;
			while (statusOut[6:0] !== pat[s] && n < 20) begin
				@(posedge clk);
				n++;
			end
			check({25'h0, statusOut[6:0]}, {25'h0, pat[s]});
		end
		test_done();
	end
endmodule
